// ==== hw/cfg_word_if.sv ====
// Word-level carrier between the serial frame engine and the register bank.
// Assumes both ends run on the same reference clock.
`default_nettype none

interface cfg_word_if;
  import rf_if_cfg_pkg::*;

  logic wr_stb; // One-cycle write request.
  logic rd_stb; // One-cycle read request.
  logic [ADDR_W-1:0] addr; // Register index of the request.
  logic [DATA_W-1:0] wdata; // Write data, valid with wr_stb.
  logic [DATA_W-1:0] rdata; // Read data, valid with rd_valid.
  logic rd_valid; // One-cycle pulse one cycle after rd_stb.

  modport engine (output wr_stb, output rd_stb, output addr, output wdata,
                  input rdata, input rd_valid);
  modport bank (input wr_stb, input rd_stb, input addr, input wdata,
                output rdata, output rd_valid);
endinterface : cfg_word_if

`default_nettype wire

// ==== hw/rf_if_cfg_pkg.sv ====
// Constants shared by the RF and IF configuration register bank.
// Assumes a single 250 MHz reference clock and a synchronously sampled serial bus.
`default_nettype none

package rf_if_cfg_pkg;

  // Serial frame geometry: 12 address bits, a read flag, 3 spare bits, then 32 data bits.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] HDR_LAST = 6'h0F;
  localparam logic [CNT_W-1:0] FRAME_LAST = 6'h2F;
  localparam int HDR_ADDR_LSB = 4;
  localparam int HDR_RW_BIT = 3;
  localparam logic RW_READ = 1'b1;

  // Register indices as printed; the serial bus addresses registers by index.
  localparam logic [ADDR_W-1:0] CFG1_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] CFG2_ADDR = 12'h001;

  // Field positions of the first configuration word.
  localparam int AMP_LSB = 15;
  localparam int MIX_LSB = 13;
  localparam int FILTER_CENTER_CODE_LSB = 6;
  localparam int FBW_LSB = 3;
  localparam int ORDER_BIT = 2;
  localparam int POLY_BIT = 1;
  localparam int GAIN_BIT = 0;

  // Field positions of the second configuration word.
  localparam int RSV31_BIT = 31;
  localparam int RSV29_LSB = 29;
  localparam int MON_BIT = 28;
  localparam int IQ_BIT = 27;
  localparam int GREF_LSB = 15;
  localparam int BIAS_LSB = 13;
  localparam int LOWF_LSB = 2;
  localparam int LOWF_W = 11;
  localparam int DIE_LSB = 0;

  // Reset values of the stored fields.
  localparam logic [1:0] AMP_RST = 2'h0;
  localparam logic [1:0] MIX_RST = 2'h0;
  localparam logic [6:0] FILTER_CENTER_CODE_RST = 7'h58;
  localparam logic [2:0] FBW_RST = 3'h0;
  localparam logic ORDER_RST = 1'b0;
  localparam logic POLY_RST = 1'b1;
  localparam logic GAIN_RST = 1'b1;
  localparam logic RSV31_RST = 1'b0;
  localparam logic [1:0] RSV29_RST = 2'h1;
  localparam logic MON_RST = 1'b0;
  localparam logic IQ_RST = 1'b0;
  localparam logic [11:0] GREF_RST = 12'h0AA;
  localparam logic [1:0] BIAS_RST = 2'h0;
  localparam logic [LOWF_W-1:0] LOWF_RST = 11'h0A2;

  // Band select codes shared by the amplifier and mixer fields.
  localparam logic [1:0] BAND_HIGH = 2'h0;
  localparam logic [1:0] BAND_LOW = 2'h1;

  // Pin bias codes.
  localparam logic [1:0] BIAS_PD = 2'h1;
  localparam logic [1:0] BIAS_PU = 2'h2;
  localparam logic [1:0] BIAS_HOLD = 2'h3;

  // Bandwidth codes and their values in units of 100 kHz.
  localparam logic [2:0] BW_C0 = 3'h0;
  localparam logic [2:0] BW_C1 = 3'h1;
  localparam logic [2:0] BW_C2 = 3'h2;
  localparam logic [2:0] BW_C3 = 3'h3;
  localparam logic [2:0] BW_C4 = 3'h4;
  localparam logic [2:0] BW_C7 = 3'h7;
  localparam logic [9:0] BW_V0 = 10'h019;
  localparam logic [9:0] BW_V1 = 10'h057;
  localparam logic [9:0] BW_V2 = 10'h02A;
  localparam logic [9:0] BW_V3 = 10'h0EA;
  localparam logic [9:0] BW_V4 = 10'h168;
  localparam logic [9:0] BW_V7 = 10'h0A4;

endpackage : rf_if_cfg_pkg

`default_nettype wire

// ==== hw/rf_if_config_registers.sv ====
// RF and IF configuration register bank with its serial access and field decode.
// Assumes a host drives the serial control pins synchronously to ref_clk.
`default_nettype none

// Behaviour
// - Amplifier code picks high, low or none.
// - Mixer code picks high, low or none.
// - Hold seven-bit filter center code, pass through.
// - Bandwidth code maps to six bandwidths.
// - Order bit: clear fifth, set third order.
// - Polyphase bit: zero lowpass, one complex bandpass.
// - Gain bit: one normal, zero minus 6dB.
// - Monitor bit routes analog I to pins.
// - Channel bit: I only, or I and Q.
// - Hold twelve-bit AGC target, reset 170.
// - Bias code sets released data pin termination.
// - Lowest two bits read die version only.
module rf_if_config_registers
  import rf_if_cfg_pkg::*;
#(
  parameter logic [1:0] DIE_VERSION = 2'h0 // Arbitrary neutral version value.
)(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic sdio_pull_down_en,
  output logic sdio_pull_up_en,
  output logic sdio_keeper_en,
  output logic hb_amp_en,
  output logic lb_amp_en,
  output logic hb_mixer_en,
  output logic lb_mixer_en,
  output logic [6:0] filter_center_code,
  output logic [9:0] filter_bw_100khz,
  output logic filter_bw_valid,
  output logic bw_mode_conflict,
  output logic filter_third_order,
  output logic filter_complex_bp,
  output logic filter_gain_reduced,
  output logic analog_i_monitor,
  output logic i_channel_en,
  output logic q_channel_en,
  output logic [11:0] agc_target_level
);

  // Word carrier between the serial engine and this bank.
  cfg_word_if bus ();

  // Stored fields of the first configuration word.
  logic [1:0] front_amp_select_q; // Front amplifier band code.
  logic [1:0] mixer_band_select_q; // Mixer band code.
  logic [6:0] filter_center_code_q; // Filter center tuning code.
  logic [2:0] filter_bw_select_q; // Filter bandwidth code.
  logic filter_order_select_q; // Filter order selection.
  logic polyphase_select_q; // Lowpass or complex bandpass.
  logic filter_gain_select_q; // Filter gain selection.

  // Stored fields of the second configuration word.
  logic rsv31_q; // Reserved bit 31, kept as written.
  logic [1:0] rsv29_q; // Reserved bits 30:29, kept as written.
  logic analog_i_monitor_q; // Analog I routing to pins.
  logic quad_channel_enable_q; // Q channel alongside I.
  logic [11:0] agc_target_level_q; // AGC reference density count.
  logic [1:0] pin_bias_q; // Data pin termination code.
  logic [LOWF_W-1:0] low_fields_q; // Output format fields held for other logic.

  // Read path registers.
  logic [DATA_W-1:0] rdata_q; // Word returned to the engine.
  logic rd_valid_q; // Answer strobe, one cycle after the request.
  logic [DATA_W-1:0] cfg1_word; // First word as seen by a read.
  logic [DATA_W-1:0] cfg2_word; // Second word as seen by a read.
  logic wr_cfg1; // Write aimed at the first word.
  logic wr_cfg2; // Write aimed at the second word.

  assign wr_cfg1 = bus.wr_stb & (bus.addr == CFG1_ADDR);
  assign wr_cfg2 = bus.wr_stb & (bus.addr == CFG2_ADDR);

  // Serial front end; it owns the pin and the frame sequencing.
  serial_frame_engine u_engine (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe(sdio_oe),
    .bus(bus.engine)
  );

  // Pin termination follows the bias code whenever the engine releases the pin.
  sdio_pad_bias u_bias (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bias_code(pin_bias_q),
    .pin_driven(sdio_oe),
    .pull_down_en(sdio_pull_down_en),
    .pull_up_en(sdio_pull_up_en),
    .keeper_en(sdio_keeper_en)
  );

  // First word storage; bits above 16 are outside this bank and are not kept.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      front_amp_select_q <= AMP_RST;
      mixer_band_select_q <= MIX_RST;
      filter_center_code_q <= FILTER_CENTER_CODE_RST;
      filter_bw_select_q <= FBW_RST;
      filter_order_select_q <= ORDER_RST;
      polyphase_select_q <= POLY_RST;
      filter_gain_select_q <= GAIN_RST;
    end else if (wr_cfg1) begin
      front_amp_select_q <= bus.wdata[AMP_LSB +: 2];
      mixer_band_select_q <= bus.wdata[MIX_LSB +: 2];
      filter_center_code_q <= bus.wdata[FILTER_CENTER_CODE_LSB +: 7];
      filter_bw_select_q <= bus.wdata[FBW_LSB +: 3];
      filter_order_select_q <= bus.wdata[ORDER_BIT];
      polyphase_select_q <= bus.wdata[POLY_BIT];
      filter_gain_select_q <= bus.wdata[GAIN_BIT];
    end
  end

  // Second word storage. The reserved bits are stored exactly as written,
  // since software is expected to write back what it read.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rsv31_q <= RSV31_RST;
      rsv29_q <= RSV29_RST;
      analog_i_monitor_q <= MON_RST;
      quad_channel_enable_q <= IQ_RST;
      agc_target_level_q <= GREF_RST;
      pin_bias_q <= BIAS_RST;
      low_fields_q <= LOWF_RST;
    end else if (wr_cfg2) begin
      rsv31_q <= bus.wdata[RSV31_BIT];
      rsv29_q <= bus.wdata[RSV29_LSB +: 2];
      analog_i_monitor_q <= bus.wdata[MON_BIT];
      quad_channel_enable_q <= bus.wdata[IQ_BIT];
      agc_target_level_q <= bus.wdata[GREF_LSB +: 12];
      pin_bias_q <= bus.wdata[BIAS_LSB +: 2];
      low_fields_q <= bus.wdata[LOWF_LSB +: LOWF_W];
      // The die version bits are not stored, so writes to them vanish.
    end
  end

  // Read images of the two words, assembled from the stored fields.
  always_comb begin
    cfg1_word = '0;
    cfg1_word[AMP_LSB +: 2] = front_amp_select_q;
    cfg1_word[MIX_LSB +: 2] = mixer_band_select_q;
    cfg1_word[FILTER_CENTER_CODE_LSB +: 7] = filter_center_code_q;
    cfg1_word[FBW_LSB +: 3] = filter_bw_select_q;
    cfg1_word[ORDER_BIT] = filter_order_select_q;
    cfg1_word[POLY_BIT] = polyphase_select_q;
    cfg1_word[GAIN_BIT] = filter_gain_select_q;
  end

  // The second word carries the fixed version code in its lowest bits.
  always_comb begin
    cfg2_word = '0;
    cfg2_word[RSV31_BIT] = rsv31_q;
    cfg2_word[RSV29_LSB +: 2] = rsv29_q;
    cfg2_word[MON_BIT] = analog_i_monitor_q;
    cfg2_word[IQ_BIT] = quad_channel_enable_q;
    cfg2_word[GREF_LSB +: 12] = agc_target_level_q;
    cfg2_word[BIAS_LSB +: 2] = pin_bias_q;
    cfg2_word[LOWF_LSB +: LOWF_W] = low_fields_q;
    cfg2_word[DIE_LSB +: 2] = DIE_VERSION;
  end

  // Read answer, registered; an unmapped index reads as zero.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= bus.rd_stb;
      if (bus.rd_stb) begin
        if (bus.addr == CFG1_ADDR) begin
          rdata_q <= cfg1_word;
        end else if (bus.addr == CFG2_ADDR) begin
          rdata_q <= cfg2_word;
        end else begin
          rdata_q <= '0;
        end
      end
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.rd_valid = rd_valid_q;

  // Amplifier and mixer enables. The reserved code 3 is treated like code 2,
  // so a bad write leaves the front end quiet rather than half powered.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hb_amp_en <= 1'b0;
      lb_amp_en <= 1'b0;
      hb_mixer_en <= 1'b0;
      lb_mixer_en <= 1'b0;
    end else begin
      hb_amp_en <= (front_amp_select_q == BAND_HIGH);
      lb_amp_en <= (front_amp_select_q == BAND_LOW);
      hb_mixer_en <= (mixer_band_select_q == BAND_HIGH);
      lb_mixer_en <= (mixer_band_select_q == BAND_LOW);
    end
  end

  // Filter bandwidth decode. Reserved codes give zero and drop the valid flag,
  // leaving the tuning logic to keep its last good setting.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      filter_bw_100khz <= '0;
      filter_bw_valid <= 1'b0;
    end else begin
      filter_bw_valid <= 1'b1;
      case (filter_bw_select_q)
        BW_C0: filter_bw_100khz <= BW_V0;
        BW_C1: filter_bw_100khz <= BW_V1;
        BW_C2: filter_bw_100khz <= BW_V2;
        BW_C3: filter_bw_100khz <= BW_V3;
        BW_C4: filter_bw_100khz <= BW_V4;
        BW_C7: filter_bw_100khz <= BW_V7;
        default: begin
          filter_bw_100khz <= '0;
          filter_bw_valid <= 1'b0;
        end
      endcase
    end
  end

  // Flag a wide bandwidth chosen with complex bandpass; the device only
  // reports it, because keeping the pair legal is the host's duty.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bw_mode_conflict <= 1'b0;
    end else begin
      bw_mode_conflict <= polyphase_select_q &
                          ((filter_bw_select_q == BW_C3) |
                           (filter_bw_select_q == BW_C4) |
                           (filter_bw_select_q == BW_C7));
    end
  end

  // Filter shape, gain and center outputs.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      filter_center_code <= FILTER_CENTER_CODE_RST;
      filter_third_order <= ORDER_RST;
      filter_complex_bp <= POLY_RST;
      filter_gain_reduced <= ~GAIN_RST;
    end else begin
      filter_center_code <= filter_center_code_q;
      filter_third_order <= filter_order_select_q;
      filter_complex_bp <= polyphase_select_q;
      filter_gain_reduced <= ~filter_gain_select_q;
    end
  end

  // Channel, monitor and AGC outputs. The I channel is always on.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      analog_i_monitor <= MON_RST;
      i_channel_en <= 1'b1;
      q_channel_en <= IQ_RST;
      agc_target_level <= GREF_RST;
    end else begin
      analog_i_monitor <= analog_i_monitor_q;
      i_channel_en <= 1'b1;
      q_channel_en <= quad_channel_enable_q;
      agc_target_level <= agc_target_level_q;
    end
  end

endmodule : rf_if_config_registers

`default_nettype wire

// ==== hw/sdio_pad_bias.sv ====
// Pad termination control for the serial data pin.
// Assumes the pad cell accepts separate pull-up, pull-down and keeper enables.
`default_nettype none

module sdio_pad_bias
  import rf_if_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [1:0] bias_code,
  input wire logic pin_driven,
  output logic pull_down_en,
  output logic pull_up_en,
  output logic keeper_en
);

  // Termination applies from one cycle after the pin is released until one cycle after it is driven.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pull_down_en <= 1'b0;
      pull_up_en <= 1'b0;
      keeper_en <= 1'b0;
    end else begin
      pull_down_en <= ~pin_driven & (bias_code == BIAS_PD);
      pull_up_en <= ~pin_driven & (bias_code == BIAS_PU);
      keeper_en <= ~pin_driven & (bias_code == BIAS_HOLD);
    end
  end

endmodule : sdio_pad_bias

`default_nettype wire

// ==== hw/serial_frame_engine.sv ====
// Serial frame engine: turns serial bus frames into word reads and writes.
// Assumes sclk, cs_n and sdio_in are synchronous to ref_clk and much slower.
`default_nettype none

module serial_frame_engine
  import rf_if_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  cfg_word_if.engine bus
);

  typedef enum logic [1:0] {PH_HEADER, PH_WRITE, PH_READ, PH_DONE} phase_type;

  phase_type phase_q; // Where the current frame stands.
  logic sclk_q; // Previous serial clock level.
  logic [CNT_W-1:0] cnt_q; // Bits taken so far in this frame.
  logic [DATA_W-1:0] shift_q; // Incoming bits, newest in bit 0.
  logic [DATA_W-1:0] out_q; // Outgoing read word, MSB first.
  logic rise; // Host clock rising edge inside a frame.
  logic [DATA_W-1:0] shift_d; // Shift register with the new bit.

  assign rise = sclk & ~sclk_q & ~cs_n;
  assign shift_d = {shift_q[DATA_W-2:0], sdio_in};
  assign sdio_out = out_q[DATA_W-1];
  assign sdio_oe = (phase_q == PH_READ) & ~cs_n;

  // Edge detection on the sampled serial clock.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  // Frame sequencing; deasserting cs_n abandons any partial frame.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= PH_HEADER;
      cnt_q <= '0;
      shift_q <= '0;
      bus.addr <= '0;
      bus.wdata <= '0;
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
    end else begin
      bus.wr_stb <= 1'b0;
      bus.rd_stb <= 1'b0;
      if (cs_n) begin
        // A short write never reaches the bank, so the word is untouched.
        phase_q <= PH_HEADER;
        cnt_q <= '0;
      end else if (rise) begin
        shift_q <= shift_d;
        cnt_q <= cnt_q + 1'b1;
        case (phase_q)
          PH_HEADER: begin
            if (cnt_q == HDR_LAST) begin
              bus.addr <= shift_d[HDR_ADDR_LSB +: ADDR_W];
              if (shift_d[HDR_RW_BIT] == RW_READ) begin
                phase_q <= PH_READ;
                bus.rd_stb <= 1'b1;
              end else begin
                phase_q <= PH_WRITE;
              end
            end
          end
          PH_WRITE: begin
            if (cnt_q == FRAME_LAST) begin
              bus.wdata <= shift_d;
              bus.wr_stb <= 1'b1;
              phase_q <= PH_DONE;
            end
          end
          PH_READ: begin
            if (cnt_q == FRAME_LAST) begin
              phase_q <= PH_DONE;
            end
          end
          default: begin
            // Extra clocks after a complete frame are ignored.
            cnt_q <= cnt_q;
          end
        endcase
      end
    end
  end

  // Read word output: loaded from the bank, shifted after each sampled bit.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= '0;
    end else if (bus.rd_valid) begin
      out_q <= bus.rdata;
    end else if (rise && phase_q == PH_READ && cnt_q != HDR_LAST) begin
      out_q <= {out_q[DATA_W-2:0], 1'b0};
    end
  end

endmodule : serial_frame_engine

`default_nettype wire

// ==== test/host_serial_model.sv ====
// Host model for the serial control bus of the configuration bank.
// Assumes the bench calls frame() and that pins change at the falling ref_clk edge.
`default_nettype none

module host_serial_model (
  input wire logic ref_clk,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic pull_up,
  input wire logic pull_down,
  input wire logic keeper,
  output logic sclk,
  output logic cs_n,
  output logic sdio_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_en = 1'b0; // High while the host drives the data pin.
  logic host_bit = 1'b0; // Bit the host puts on the pin.
  logic last_q = 1'b0; // Last driven pin level, for the keeper.

  // A floating pin shows the inverse of its last level, so no stale value looks valid.
  always_comb begin
    sdio_line = sdio_oe ? sdio_out : host_en ? host_bit : pull_up ? 1'b1 :
      pull_down ? 1'b0 : keeper ? last_q : ~last_q;
  end

  // Remember the driven level so a keeper can hold it.
  always @(posedge ref_clk) begin
    if (sdio_oe || host_en) begin
      last_q <= sdio_line;
    end
  end

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end

  // One frame MSB first; fewer than 48 bits aborts it. Clock phases last 4 cycles each.
  task automatic frame(input logic [11:0] addr, input logic rd, input logic [31:0] wdata,
    input int nbits, output logic [31:0] rdata);
    logic [47:0] sh;
    sh = {addr, rd, 3'h0, wdata};
    rdata = 32'h0000_0000;
    @(negedge ref_clk);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      host_en = !(rd && i >= 16);
      host_bit = sh[47-i];
      repeat (4) @(negedge ref_clk);
      sclk = 1'b1;
      if (i >= 16) begin
        rdata = {rdata[30:0], sdio_line};
      end
      repeat (4) @(negedge ref_clk);
      sclk = 1'b0;
    end
    host_en = 1'b0;
    repeat (4) @(negedge ref_clk);
    cs_n = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask
endmodule // host_serial_model

`default_nettype wire

// ==== test/rf_if_config_registers_properties.sv ====
// Checker for the RF and IF configuration bank, bound to its top-level ports.
// Assumes one ref_clk domain with resetn as an asynchronous active-low reset.
`default_nettype none

module rf_if_config_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sdio_oe,
  input wire logic sdio_pull_down_en,
  input wire logic sdio_pull_up_en,
  input wire logic sdio_keeper_en,
  input wire logic hb_amp_en,
  input wire logic lb_amp_en,
  input wire logic hb_mixer_en,
  input wire logic lb_mixer_en,
  input wire logic [9:0] filter_bw_100khz,
  input wire logic filter_bw_valid,
  input wire logic bw_mode_conflict,
  input wire logic filter_complex_bp,
  input wire logic i_channel_en,
  input wire logic [11:0] agc_target_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [3:0] idle_q; // Cycles since cs_n was last low, saturating.

  // Field changes must follow a frame closely; this counts the quiet time since one.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      idle_q <= 4'hF;
    end else if (!cs_n) begin
      idle_q <= 4'h0;
    end else if (idle_q != 4'hF) begin
      idle_q <= idle_q + 4'h1;
    end
  end

  AST_AMP_EXCL: assert property (!(hb_amp_en && lb_amp_en))
    else $error("both amplifier enables high");
  AST_MIX_EXCL: assert property (!(hb_mixer_en && lb_mixer_en))
    else $error("both mixer enables high");
  AST_BW_TABLE: assert property (filter_bw_valid |-> filter_bw_100khz inside
    {10'h019, 10'h057, 10'h02A, 10'h0EA, 10'h168, 10'h0A4}) else $error("bandwidth off table");
  AST_BW_RSVD: assert property (!filter_bw_valid |-> filter_bw_100khz == 10'h000)
    else $error("reserved bandwidth not zero");
  AST_CONFLICT: assert property (bw_mode_conflict == (filter_complex_bp &&
    filter_bw_100khz inside {10'h0EA, 10'h168, 10'h0A4})) else $error("conflict flag wrong");
  AST_I_ON: assert property (i_channel_en)
    else $error("I channel disabled");
  AST_PULL_OFF: assert property (sdio_oe |=> !(sdio_pull_up_en || sdio_pull_down_en))
    else $error("pull active while pin driven");
  AST_PULL_ONE: assert property ($onehot0({sdio_pull_up_en, sdio_pull_down_en, sdio_keeper_en}))
    else $error("more than one termination");
  AST_OE_SEL: assert property (cs_n |-> !sdio_oe)
    else $error("data pin driven while deselected");
  AST_AGC_QUIET: assert property (!$stable(agc_target_level) |-> idle_q < 4'h3)
    else $error("target changed outside a frame");
  AST_RST_VALS: assert property ($rose(resetn) |-> agc_target_level == 12'h0AA
    && filter_complex_bp) else $error("reset values wrong");

  cover property ($rose(sdio_oe));
  cover property (bw_mode_conflict);
  cover property (!$stable(agc_target_level));
endmodule // rf_if_config_checker

bind rf_if_config_registers rf_if_config_checker u_checker (
  .ref_clk, .resetn, .cs_n, .sdio_oe, .sdio_pull_down_en, .sdio_pull_up_en, .sdio_keeper_en,
  .hb_amp_en, .lb_amp_en, .hb_mixer_en, .lb_mixer_en, .filter_bw_100khz, .filter_bw_valid,
  .bw_mode_conflict, .filter_complex_bp, .i_channel_en, .agc_target_level
);

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the configuration bank through its serial port.
// Assumes the host model's timing and the default die version of zero.
`default_nettype none

module tb
  import rf_if_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0; // 250 MHz reference clock.
  logic resetn = 1'b0; // Active-low reset, asserted from time zero.
  logic sclk, cs_n, sdio_line, sdio_out, sdio_oe, sdio_pull_down_en, sdio_pull_up_en;
  logic sdio_keeper_en, hb_amp_en, lb_amp_en, hb_mixer_en, lb_mixer_en, filter_bw_valid;
  logic bw_mode_conflict, filter_third_order, filter_complex_bp, filter_gain_reduced;
  logic analog_i_monitor, i_channel_en, q_channel_en;
  logic [6:0] filter_center_code;
  logic [9:0] filter_bw_100khz;
  logic [11:0] agc_target_level;
  logic [9:0] bw_tab [8] = '{10'h019, 10'h057, 10'h02A, 10'h0EA, 10'h168, 10'h000, 10'h000,
    10'h0A4}; // Bandwidth per code in 100 kHz steps.
  int failures = 0;
  int checks_done = 0;

  rf_if_config_registers #(.DIE_VERSION(2'h0)) u_rf_if_config_registers (
    .ref_clk, .resetn, .sclk, .cs_n, .sdio_in(sdio_line), .sdio_out, .sdio_oe,
    .sdio_pull_down_en, .sdio_pull_up_en, .sdio_keeper_en, .hb_amp_en, .lb_amp_en,
    .hb_mixer_en, .lb_mixer_en, .filter_center_code, .filter_bw_100khz, .filter_bw_valid,
    .bw_mode_conflict, .filter_third_order, .filter_complex_bp, .filter_gain_reduced,
    .analog_i_monitor, .i_channel_en, .q_channel_en, .agc_target_level
  );

  host_serial_model u_host (
    .ref_clk, .sdio_out, .sdio_oe, .pull_up(sdio_pull_up_en), .pull_down(sdio_pull_down_en),
    .keeper(sdio_keeper_en), .sclk, .cs_n, .sdio_line
  );

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_host.frame(a, ~RW_READ, d, 48, r);
  endtask

  task automatic rd_word(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    u_host.frame(a, RW_READ, 32'h0000_0000, 48, r);
    check(what, exp, r);
  endtask

  // Reset for 12 cycles, then compare the reset image of both words.
  task automatic reset_and_check();
    @(negedge ref_clk);
    resetn = 1'b0;
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("agc", 12'h0AA, agc_target_level);
    check("center", 7'h58, filter_center_code);
    check("bw", 10'h019, filter_bw_100khz);
    rd_word(CFG1_ADDR, 32'h0000_1603, "word1 reset");
    rd_word(CFG2_ADDR, 32'h2055_0288, "word2 reset");
    $display("test reset done");
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hang is cut short here and counted as a mismatch.
  initial begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    give_verdict();
  end

  initial begin
    logic [16:0] lo;
    logic [31:0] w, r;
    logic [11:0] g;
    reset_and_check();
    // Every code of each word-1 field except the center code, which gets eight values; upper bits are written as ones and must read zero.
    for (int i = 0; i < 8; i++) begin
      lo = {i[1:0], i[2:1], i[2:0], i[3:0], i[2:0], i[0], i[1], i[2]};
      wr(CFG1_ADDR, {15'h7FFF, lo});
      check("amp", {i[1:0] == 2'h0, i[1:0] == 2'h1}, {hb_amp_en, lb_amp_en});
      check("mixer", {i[2:1] == 2'h0, i[2:1] == 2'h1}, {hb_mixer_en, lb_mixer_en});
      check("center", {i[2:0], i[3:0]}, filter_center_code);
      check("bw", {bw_tab[i], !(i inside {5, 6})}, {filter_bw_100khz, filter_bw_valid});
      check("conflict", i[1] && (i inside {3, 4, 7}), bw_mode_conflict);
      check("order", i[0], filter_third_order);
      check("poly", i[1], filter_complex_bp);
      check("gain", !i[2], filter_gain_reduced);
      rd_word(CFG1_ADDR, {15'h0000, lo}, "word1");
    end
    $display("test word1 done");
    // Word 2 is read first so its reserved bits go back unchanged.
    for (int j = 0; j < 4; j++) begin
      u_host.frame(CFG2_ADDR, RW_READ, 32'h0000_0000, 48, r);
      g = 12'h555 * j[1:0];
      w = {r[31:29], j[0], j[1], g, j[1:0], r[12:2], 2'h3};
      wr(CFG2_ADDR, w);
      check("monitor", j[0], analog_i_monitor);
      check("channels", {1'b1, j[1]}, {i_channel_en, q_channel_en});
      check("agc", g, agc_target_level);
      check("pulls", {j == 2, j == 1, j == 3},
        {sdio_pull_up_en, sdio_pull_down_en, sdio_keeper_en});
      rd_word(CFG2_ADDR, {w[31:2], 2'h0}, "word2");
    end
    $display("test word2 done");
    rd_word(12'h005, 32'h0000_0000, "unmapped");
    wr(12'h002, 32'h0000_0000);
    u_host.frame(CFG2_ADDR, ~RW_READ, 32'h0000_0000, 47, r);
    check("agc kept", 12'hFFF, agc_target_level);
    $display("test refusals done");
    reset_and_check();
    give_verdict();
  end
endmodule // tb

`default_nettype wire
